// ---- motion_profile_generator.sv ----
// motion profile generator: trapezoidal speed ramp, speed cap, jerk filter, parameter port
// Function
// - the reference profile is computed from target position and speed, shaped by the mode.
// - acceleration and deceleration both use a linear speed ramp in the four profiled modes.
// - the same slopes apply in both directions of rotation.
// - acceleration slope is a 32-bit rpm/s setting, 1 to 3000000, default 600.
// - deceleration slope is a 32-bit rpm/s setting, 200 to 3000000, default 750.
// - the speed cap is a 16-bit rpm setting, 60 to 13200, default 13200.
// - a requested speed above the cap is silently clamped to the cap.
// - the cap is enforced only in profile position, profile velocity, homing and jog.
// - the ramp output passes a jerk filter that smooths acceleration steps.
// - jerk filter time is 0 (off) or 1, 2, 4, 8, 16, 32, 64 or 128 ms, default 0.
// - jerk limiting acts at all four ramp transitions.
// - jerk limiting is processed only in the four profiled modes.
// - motion done rises only once the ramp has stopped and the filtered position has reached the ramp position.
// - the jerk time may be changed only while motion done is 1.
`timescale 1ns/1ps
module motion_profile_generator
    import motion_profile_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic rst,
    input wire op_mode_e op_mode,
    input wire logic move_start,
    input wire logic signed [POS_W-1:0] target_position,
    input wire logic [15:0] target_speed,
    input wire logic target_reverse,
    input wire logic param_wr,
    input wire logic param_rd,
    input wire logic [ADDR_W-1:0] param_addr,
    input wire logic [DATA_W-1:0] param_wdata,
    output logic param_ack,
    output logic param_err,
    output logic [DATA_W-1:0] param_rdata,
    output logic signed [POS_W-1:0] ref_position,
    output logic signed [POS_W-1:0] ref_speed,
    output logic ramp_active,
    output logic motion_done
);
    localparam int CNT_W = $clog2(TICK_CYCLES);
    localparam int BRK_W = SPD_W + POS_W + 1;

    typedef enum logic {st_idle, st_run} ramp_state_e;

    ramp_state_e state_q;
    op_mode_e mode_q;
    logic [15:0] cap_q;
    logic [31:0] accel_q;
    logic [31:0] decel_q;
    logic [15:0] jerk_q;
    logic [CNT_W-1:0] cnt_q;
    logic tick_q;
    logic flt_tick_q;
    logic signed [POS_W-1:0] tgt_pos_q;
    logic [15:0] tgt_speed_q;
    logic tgt_rev_q;
    logic signed [SPD_W-1:0] spd_q;
    logic signed [SPD_W-1:0] spd_d;
    logic signed [POS_W-1:0] pos_q;
    logic done_q;
    logic ack_q;
    logic err_q;
    logic [DATA_W-1:0] rdata_q;

    logic profiled;
    logic [15:0] lim_rpm;
    logic [SPD_W-1:0] vlim;
    logic [SPD_W-1:0] cap_spd;
    logic signed [POS_W-1:0] rem;
    logic [POS_W-1:0] rem_mag;
    logic [SPD_W-1:0] spd_mag;
    logic [2*SPD_W-1:0] v2;
    logic [BRK_W-1:0] brake_dist;
    logic brake;
    logic signed [SPD_W-1:0] desired;
    logic [SPD_W-1:0] des_mag;
    logic accelerating;
    logic signed [SPD_W:0] slope_s;
    logic signed [SPD_W:0] gap;
    logic finish;
    logic halt_done;
    logic hit;
    logic wr_ok;
    logic [DATA_W-1:0] rd_val;

    jerk_if jf ();

    jerk_filter u_filter (
        .clock(clock),
        .rst(rst),
        .jf(jf.filt)
    );

    function automatic logic [3:0] jerk_shift(input logic [15:0] t);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 0; i < 8; i++) begin
            if (t[i]) begin
                s = 4'(i + JERK_BASE_SHIFT);
            end
        end
        return s;
    endfunction

    // profile tick divider: one enable pulse per update period
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (cnt_q == CNT_W'(TICK_CYCLES - 1)) begin
            cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // filter runs one cycle after the ramp so it sees the updated position
    always_ff @(posedge clock) begin
        if (rst) begin
            flt_tick_q <= 1'b0;
        end else begin
            flt_tick_q <= tick_q;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mode_q <= mode_off;
            tgt_pos_q <= '0;
            tgt_speed_q <= 16'h0000;
            tgt_rev_q <= 1'b0;
        end else if (move_start) begin
            mode_q <= op_mode;
            tgt_pos_q <= target_position;
            tgt_speed_q <= target_speed;
            tgt_rev_q <= target_reverse;
        end
    end

    // speeds are held in units of 1/TICK_HZ rpm so one tick adds exactly the slope value
    always_comb begin
        profiled = mode_q inside {mode_profile_position, mode_profile_velocity,
                                  mode_homing, mode_jog};
        lim_rpm = (profiled && tgt_speed_q > cap_q) ? cap_q : tgt_speed_q;
        vlim = (mode_q == mode_off) ? '0 : SPD_W'(lim_rpm) * SPD_W'(TICK_HZ);
        cap_spd = SPD_W'(cap_q) * SPD_W'(TICK_HZ);
        rem = tgt_pos_q - pos_q;
        rem_mag = rem[POS_W-1] ? POS_W'(-rem) : POS_W'(rem);
        spd_mag = spd_q[SPD_W-1] ? SPD_W'(-spd_q) : SPD_W'(spd_q);
        v2 = (2*SPD_W)'(spd_mag) * (2*SPD_W)'(spd_mag);
        // start braking once v^2 reaches 2*decel*distance left
        brake_dist = BRK_W'({decel_q, 1'b0}) * BRK_W'(rem_mag);
        brake = BRK_W'(v2) >= brake_dist;
        if (mode_q == mode_profile_position) begin
            if (brake || rem == '0) begin
                desired = '0;
            end else begin
                desired = rem[POS_W-1] ? -$signed(vlim) : $signed(vlim);
            end
        end else begin
            desired = tgt_rev_q ? -$signed(vlim) : $signed(vlim);
        end
        des_mag = desired[SPD_W-1] ? SPD_W'(-desired) : SPD_W'(desired);
        // magnitude grows toward the same sign: acceleration slope, else deceleration
        accelerating = (spd_q == '0 || desired[SPD_W-1] == spd_q[SPD_W-1]) && des_mag > spd_mag;
        slope_s = $signed({1'b0, accelerating ? accel_q : decel_q});
        gap = $signed({desired[SPD_W-1], desired}) - $signed({spd_q[SPD_W-1], spd_q});
        if (!profiled) begin
            spd_d = desired;
        end else if (gap > slope_s) begin
            spd_d = spd_q + SPD_W'(slope_s);
        end else if (gap < -slope_s) begin
            spd_d = spd_q - SPD_W'(slope_s);
        end else begin
            spd_d = desired;
        end
        finish = (mode_q == mode_profile_position) && spd_mag <= decel_q
                 && rem_mag <= POS_W'(spd_mag) + POS_W'(decel_q);
        halt_done = (mode_q != mode_profile_position) && desired == '0 && spd_q == '0;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= st_idle;
            spd_q <= '0;
            pos_q <= '0;
        end else if (move_start) begin
            state_q <= st_run;
        end else if (tick_q && state_q == st_run) begin
            if (finish) begin
                pos_q <= tgt_pos_q;
                spd_q <= '0;
                state_q <= st_idle;
            end else if (halt_done) begin
                state_q <= st_idle;
            end else begin
                spd_q <= spd_d;
                pos_q <= pos_q + {{(POS_W-SPD_W){spd_d[SPD_W-1]}}, spd_d};
            end
        end
    end

    assign jf.tick = flt_tick_q;
    assign jf.raw_pos = pos_q;
    assign jf.en = profiled && jerk_q != 16'h0000;
    assign jf.shift = jerk_shift(jerk_q);

    // done waits for the filter as well as the ramp: the filtered position lags the ramp
    always_ff @(posedge clock) begin
        if (rst) begin
            done_q <= 1'b1;
        end else begin
            done_q <= !move_start && state_q == st_idle && jf.settled;
        end
    end

    // parameter port decode and range checks
    always_comb begin
        hit = 1'b1;
        wr_ok = 1'b0;
        rd_val = '0;
        unique case (param_addr)
            REG_SPEED_CAP: begin
                rd_val = {16'h0000, cap_q};
                wr_ok = param_wdata[31:16] == 16'h0000 && param_wdata[15:0] >= CAP_MIN
                        && param_wdata[15:0] <= CAP_MAX;
            end
            REG_ACCEL: begin
                rd_val = accel_q;
                wr_ok = param_wdata >= ACCEL_MIN && param_wdata <= SLOPE_MAX;
            end
            REG_DECEL: begin
                rd_val = decel_q;
                wr_ok = param_wdata >= DECEL_MIN && param_wdata <= SLOPE_MAX;
            end
            REG_JERK: begin
                rd_val = {16'h0000, jerk_q};
                wr_ok = done_q && param_wdata[31:16] == 16'h0000
                        && param_wdata[15:0] <= JERK_MAX
                        && (param_wdata[15:0] & (param_wdata[15:0] - 16'h0001)) == 16'h0000;
            end
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cap_q <= RST_SPEED_CAP;
            accel_q <= RST_ACCEL;
            decel_q <= RST_DECEL;
            jerk_q <= RST_JERK;
        end else if (param_wr && hit && wr_ok) begin
            if (param_addr == REG_SPEED_CAP) cap_q <= param_wdata[15:0];
            if (param_addr == REG_ACCEL) accel_q <= param_wdata;
            if (param_addr == REG_DECEL) decel_q <= param_wdata;
            if (param_addr == REG_JERK) jerk_q <= param_wdata[15:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= param_wr || param_rd;
            err_q <= (param_wr && !(hit && wr_ok)) || (param_rd && !hit);
            if (param_rd) rdata_q <= rd_val;
        end
    end

    assign param_ack = ack_q;
    assign param_err = err_q;
    assign param_rdata = rdata_q;
    assign ref_position = jf.filt_pos;
    assign ref_speed = jf.filt_delta;
    assign ramp_active = (state_q == st_run);
    assign motion_done = done_q;

    // checking helpers
    logic signed [SPD_W-1:0] spd_prev_q;
    logic [SPD_W:0] step_mag;
    logic [31:0] slope_max;
    always_ff @(posedge clock) begin
        if (rst) spd_prev_q <= '0;
        else spd_prev_q <= spd_q;
    end
    always_comb begin
        step_mag = (spd_q >= spd_prev_q) ? (SPD_W+1)'(spd_q - spd_prev_q)
                                         : (SPD_W+1)'(spd_prev_q - spd_q);
        slope_max = (accel_q > decel_q) ? accel_q : decel_q;
    end

    property p_linear_step;
        @(posedge clock) disable iff (rst)
        (tick_q && !move_start && state_q == st_run && profiled)
            |=> step_mag <= {1'b0, $past(slope_max)};
    endproperty
    a_linear_step: assert property (p_linear_step) else $error("ramp step too large");

    property p_speed_cap;
        @(posedge clock) disable iff (rst)
        (tick_q && state_q == st_run && profiled)
            |=> (spd_mag <= $past(spd_mag)) || (spd_mag <= $past(cap_spd));
    endproperty
    a_speed_cap: assert property (p_speed_cap) else $error("speed above cap");

    property p_done_after_filter;
        @(posedge clock) disable iff (rst)
        $rose(done_q) |-> $past(jf.settled) && $past(state_q == st_idle);
    endproperty
    a_done_after_filter: assert property (p_done_after_filter) else $error("early done");

    property p_position_reached;
        @(posedge clock) disable iff (rst)
        ($fell(state_q == st_run) && mode_q == mode_profile_position) |-> pos_q == tgt_pos_q;
    endproperty
    a_position_reached: assert property (p_position_reached) else $error("target missed");

    property p_jerk_locked;
        @(posedge clock) disable iff (rst)
        (param_wr && param_addr == REG_JERK && !done_q) |=> $stable(jerk_q) && err_q && ack_q;
    endproperty
    a_jerk_locked: assert property (p_jerk_locked) else $error("jerk changed in motion");

    property p_accel_range;
        @(posedge clock) disable iff (rst)
        (param_wr && param_addr == REG_ACCEL && param_wdata == '0) |=> $stable(accel_q) && err_q;
    endproperty
    a_accel_range: assert property (p_accel_range) else $error("bad accel taken");

    property p_cap_write;
        @(posedge clock) disable iff (rst)
        (param_wr && param_addr == REG_SPEED_CAP && param_wdata[31:16] == 16'h0000
         && param_wdata[15:0] >= CAP_MIN && param_wdata[15:0] <= CAP_MAX)
            |=> cap_q == $past(param_wdata[15:0]) && !err_q;
    endproperty
    a_cap_write: assert property (p_cap_write) else $error("cap write lost");

    property p_decel_floor;
        @(posedge clock) disable iff (rst)
        1'b1 |-> decel_q >= DECEL_MIN && decel_q <= SLOPE_MAX && accel_q >= ACCEL_MIN;
    endproperty
    a_decel_floor: assert property (p_decel_floor) else $error("slope out of range");
endmodule

// ---- motion_profile_pkg.sv ----
// constants and types shared by the motion profile generator and its jerk filter
package motion_profile_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int POS_W = 48;
    localparam int SPD_W = 32;

    // parameter addresses, as seen on the parameter port
    localparam logic [ADDR_W-1:0] REG_SPEED_CAP = 16'h0612;
    localparam logic [ADDR_W-1:0] REG_ACCEL = 16'h0614;
    localparam logic [ADDR_W-1:0] REG_DECEL = 16'h0616;
    localparam logic [ADDR_W-1:0] REG_JERK = 16'h061a;

    localparam logic [15:0] RST_SPEED_CAP = 16'h3390;
    localparam logic [31:0] RST_ACCEL = 32'h0000_0258;
    localparam logic [31:0] RST_DECEL = 32'h0000_02ee;
    localparam logic [15:0] RST_JERK = 16'h0000;

    localparam logic [15:0] CAP_MIN = 16'h003c;
    localparam logic [15:0] CAP_MAX = 16'h3390;
    localparam logic [31:0] ACCEL_MIN = 32'h0000_0001;
    localparam logic [31:0] DECEL_MIN = 32'h0000_00c8;
    localparam logic [31:0] SLOPE_MAX = 32'h002d_c6c0;
    localparam logic [15:0] JERK_MAX = 16'h0080;

    // profile update tick
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_US = 125;
    localparam int TICK_HZ = 1_000_000 / TICK_US;
    localparam int TICK_CYCLES_DEF = CLK_HZ / 1_000_000 * TICK_US;
    localparam int TICKS_PER_MS = 1000 / TICK_US;
    localparam int JERK_BASE_SHIFT = $clog2(TICKS_PER_MS);

    typedef enum logic [2:0] {
        mode_off,
        mode_profile_position,
        mode_profile_velocity,
        mode_homing,
        mode_jog,
        mode_direct
    } op_mode_e;
endpackage

// ---- jerk_if.sv ----
// link between the ramp generator and the jerk filter
`timescale 1ns/1ps
interface jerk_if
    import motion_profile_pkg::*;
();
    logic tick;
    logic en;
    logic [3:0] shift;
    logic signed [POS_W-1:0] raw_pos;
    logic signed [POS_W-1:0] filt_pos;
    logic signed [POS_W-1:0] filt_delta;
    logic settled;

    modport ramp (output tick, en, shift, raw_pos, input filt_pos, filt_delta, settled);
    modport filt (input tick, en, shift, raw_pos, output filt_pos, filt_delta, settled);
endinterface

// ---- jerk_filter.sv ----
// jerk filter: first-order smoothing of the ramp reference position
`timescale 1ns/1ps
module jerk_filter
    import motion_profile_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    jerk_if.filt jf
);
    logic signed [POS_W-1:0] diff;
    logic signed [POS_W-1:0] step;
    logic snap;

    // a residue smaller than one step is taken whole, so the filter ends exactly on target
    always_comb begin
        diff = jf.raw_pos - jf.filt_pos;
        step = diff >>> jf.shift;
        snap = !jf.en || step == '0 || step == '1;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            jf.filt_pos <= '0;
            jf.filt_delta <= '0;
        end else if (jf.tick) begin
            jf.filt_pos <= snap ? jf.raw_pos : jf.filt_pos + step;
            jf.filt_delta <= snap ? diff : step;
        end
    end

    assign jf.settled = (jf.filt_pos == jf.raw_pos);

    property p_bypass;
        @(posedge clock) disable iff (rst)
        (jf.tick && !jf.en) |=> (jf.filt_pos == $past(jf.raw_pos));
    endproperty
    a_bypass: assert property (p_bypass) else $error("filter not bypassed");

    property p_no_overshoot;
        @(posedge clock) disable iff (rst)
        (jf.tick && jf.en && diff > 0)
            |=> (jf.filt_pos <= $past(jf.raw_pos)) && (jf.filt_pos > $past(jf.filt_pos));
    endproperty
    a_no_overshoot: assert property (p_no_overshoot) else $error("filter overshoot");
endmodule

// ---- motor_loop_model.sv ----
// passive model of the position loop and power stage that follow the reference profile
`timescale 1ns/1ps
module motor_loop_model
    import motion_profile_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic signed [POS_W-1:0] ref_position,
    output logic signed [POS_W-1:0] motor_pos_q
);
    // a stiff loop: the shaft lands on the reference one control cycle later
    always_ff @(posedge clock) begin
        if (rst) begin
            motor_pos_q <= '0;
        end else begin
            motor_pos_q <= ref_position;
        end
    end
endmodule

// ---- motion_profile_generator_tb_top.sv ----
// self-checking testbench for the motion profile generator
`timescale 1ns/1ps
module motion_profile_generator_tb_top
    import motion_profile_pkg::*;
;
    // short tick so a move takes hundreds of clocks rather than tens of thousands
    localparam int T = 20;
    logic clock, rst, move_start, target_reverse, param_wr, param_rd;
    op_mode_e op_mode;
    logic signed [POS_W-1:0] target_position;
    logic [15:0] target_speed;
    logic [ADDR_W-1:0] param_addr;
    logic [DATA_W-1:0] param_wdata;
    logic param_ack, param_err, ramp_active, motion_done;
    logic [DATA_W-1:0] param_rdata;
    logic signed [POS_W-1:0] ref_position, ref_speed, motor_pos_q;
    logic signed [POS_W-1:0] a1, a2, a3, b1, b2, b3;
    int err_count, n_tests;

    motion_profile_generator #(.TICK_CYCLES(T)) u_motion_profile_generator (
        .clock(clock), .rst(rst), .op_mode(op_mode), .move_start(move_start),
        .target_position(target_position), .target_speed(target_speed),
        .target_reverse(target_reverse), .param_wr(param_wr), .param_rd(param_rd),
        .param_addr(param_addr), .param_wdata(param_wdata), .param_ack(param_ack),
        .param_err(param_err), .param_rdata(param_rdata), .ref_position(ref_position),
        .ref_speed(ref_speed), .ramp_active(ramp_active), .motion_done(motion_done));

    motor_loop_model u_motor_loop_model (
        .clock(clock), .rst(rst), .ref_position(ref_position), .motor_pos_q(motor_pos_q));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(string what, logic [63:0] exp, logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(logic [15:0] a, logic [31:0] d, logic e);
        @(posedge clock);
        param_wr <= 1'b1;
        param_addr <= a;
        param_wdata <= d;
        @(posedge clock);
        param_wr <= 1'b0;
        #1;
        check("write ack", 1, param_ack);
        check("write err", e, param_err);
    endtask

    task automatic rd(logic [15:0] a, logic [31:0] d, logic e);
        @(posedge clock);
        param_rd <= 1'b1;
        param_addr <= a;
        @(posedge clock);
        param_rd <= 1'b0;
        #1;
        check("read ack", 1, param_ack);
        check("read err", e, param_err);
        if (!e) check("read data", d, param_rdata);
    endtask

    task automatic start(op_mode_e m, logic signed [POS_W-1:0] p, logic [15:0] s, logic r);
        @(posedge clock);
        op_mode <= m;
        target_position <= p;
        target_speed <= s;
        target_reverse <= r;
        move_start <= 1'b1;
        @(posedge clock);
        move_start <= 1'b0;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        #1;
        while (motion_done !== 1'b1 && n < 30000) begin
            @(posedge clock);
            #1;
            n++;
        end
        check("motion done", 1, motion_done);
    endtask

    // sampled a whole tick apart, so any tick phase gives three consecutive speeds
    task automatic speeds(output logic signed [POS_W-1:0] s1, s2, s3);
        repeat (3 * T) @(posedge clock);
        #1 s1 = ref_speed;
        repeat (T) @(posedge clock);
        #1 s2 = ref_speed;
        repeat (T) @(posedge clock);
        #1 s3 = ref_speed;
    endtask

    task automatic test_regs();
        rd(REG_SPEED_CAP, 32'h0000_3390, 1'b0);
        rd(REG_ACCEL, 32'h0000_0258, 1'b0);
        rd(REG_DECEL, 32'h0000_02ee, 1'b0);
        rd(REG_JERK, 32'h0000_0000, 1'b0);
        rd(16'h0618, 32'h0, 1'b1);
        wr(REG_SPEED_CAP, 32'h0000_003b, 1'b1);
        wr(REG_SPEED_CAP, 32'h0000_3391, 1'b1);
        wr(REG_SPEED_CAP, 32'h0001_003c, 1'b1);
        wr(REG_SPEED_CAP, 32'h0000_003c, 1'b0);
        rd(REG_SPEED_CAP, 32'h0000_003c, 1'b0);
        wr(REG_SPEED_CAP, 32'h0000_3390, 1'b0);
        wr(REG_ACCEL, 32'h0000_0000, 1'b1);
        wr(REG_ACCEL, 32'h002d_c6c1, 1'b1);
        wr(REG_ACCEL, 32'h0000_0001, 1'b0);
        wr(REG_ACCEL, 32'h002d_c6c0, 1'b0);
        rd(REG_ACCEL, 32'h002d_c6c0, 1'b0);
        wr(REG_DECEL, 32'h0000_00c7, 1'b1);
        wr(REG_DECEL, 32'h0000_00c8, 1'b0);
        rd(REG_DECEL, 32'h0000_00c8, 1'b0);
        wr(REG_JERK, 32'h0000_0003, 1'b1);
        wr(REG_JERK, 32'h0000_0081, 1'b1);
        wr(REG_JERK, 32'h0001_0080, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wr(REG_JERK, 32'h1 << i, 1'b0);
            rd(REG_JERK, 32'h1 << i, 1'b0);
        end
        wr(REG_JERK, 32'h0, 1'b0);
        $display("register test done");
    endtask

    task automatic test_ramp();
        wr(REG_ACCEL, 32'h0000_1f40, 1'b0);
        wr(REG_DECEL, 32'h002d_c6c0, 1'b0);
        start(mode_profile_velocity, '0, 16'h03e8, 1'b0);
        speeds(a1, a2, a3);
        check("rising slope", 1, (a2 - a1) > 0);
        check("even slope", a2 - a1, a3 - a2);
        start(mode_profile_velocity, '0, 16'h0000, 1'b0);
        wait_done();
        start(mode_profile_velocity, '0, 16'h03e8, 1'b1);
        speeds(b1, b2, b3);
        check("reverse slope", a1 - a2, b2 - b1);
        check("reverse slope next", a1 - a2, b3 - b2);
        start(mode_profile_velocity, '0, 16'h0000, 1'b1);
        wait_done();
        $display("ramp test done");
    endtask

    task automatic test_jerk();
        wr(REG_JERK, 32'h0000_0008, 1'b0);
        start(mode_profile_velocity, '0, 16'h03e8, 1'b0);
        speeds(b1, b2, b3);
        check("smoothed slope", 1, (b2 - b1) < (a2 - a1));
        wr(REG_JERK, 32'h0000_0000, 1'b1);
        rd(REG_JERK, 32'h0000_0008, 1'b0);
        start(mode_profile_velocity, '0, 16'h0000, 1'b0);
        wait_done();
        $display("jerk test done");
    endtask

    task automatic test_position();
        logic fell, done_at_fall;
        int n;
        fell = 1'b0;
        done_at_fall = 1'b1;
        n = 0;
        start(mode_profile_position, 48'sd2000000, 16'h03e8, 1'b0);
        #1;
        check("ramp running", 1, ramp_active);
        check("done cleared", 0, motion_done);
        while (motion_done !== 1'b1 && n < 30000) begin
            if (!fell && ramp_active === 1'b0) begin
                fell = 1'b1;
                done_at_fall = motion_done;
            end
            @(posedge clock);
            #1;
            n++;
        end
        check("ramp ended", 1, fell);
        check("done at ramp end", 0, done_at_fall);
        check("motion done", 1, motion_done);
        check("reference at target", 48'sd2000000, ref_position);
        @(posedge clock);
        #1;
        check("motor at target", 48'sd2000000, motor_pos_q);
        wr(REG_JERK, 32'h0, 1'b0);
        $display("position test done");
    endtask

    task automatic test_cap();
        op_mode_e modes [3];
        modes = '{mode_profile_velocity, mode_homing, mode_jog};
        wr(REG_ACCEL, 32'h002d_c6c0, 1'b0);
        wr(REG_SPEED_CAP, 32'h0000_003c, 1'b0);
        foreach (modes[i]) begin
            start(modes[i], '0, 16'h0064, 1'b0);
            repeat (4 * T) @(posedge clock);
            #1;
            check("capped speed", 64'd480000, ref_speed);
            start(modes[i], '0, 16'h0000, 1'b0);
            wait_done();
        end
        start(mode_direct, '0, 16'h0064, 1'b0);
        repeat (4 * T) @(posedge clock);
        #1;
        check("uncapped speed", 64'd800000, ref_speed);
        // off must zero the reference speed whatever speed is requested
        start(mode_off, '0, 16'h0064, 1'b0);
        repeat (4 * T) @(posedge clock);
        #1;
        check("off speed", 64'd0, ref_speed);
        wr(REG_SPEED_CAP, 32'h0000_3390, 1'b0);
        $display("cap test done");
    endtask

    initial begin
        err_count = 0;
        n_tests = 0;
        rst = 1'b1;
        op_mode = mode_off;
        move_start = 1'b0;
        target_position = '0;
        target_speed = 16'h0000;
        target_reverse = 1'b0;
        param_wr = 1'b0;
        param_rd = 1'b0;
        param_addr = 16'h0000;
        param_wdata = 32'h0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        test_regs();
        test_ramp();
        test_jerk();
        test_position();
        test_cap();
        print_verdict();
    end

    // the sequence needs well under half of this span
    initial begin
        repeat (100000) @(posedge clock);
        err_count++;
        print_verdict();
    end
endmodule
